// [design/qcs_pkg.sv]
package qcs_pkg;

	// ----------------------------------------------------------------
	// Sizes and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CHANNELS         = 4;
	localparam int unsigned LINES            = 2;
	localparam int unsigned LINE_SCL         = 0;
	localparam int unsigned LINE_SDA         = 1;
	localparam logic [3:0]  SEL_RESET        = 4'h0;
	localparam logic [3:0]  BYTE_BITS        = 4'h8;
	localparam logic [3:0]  READ_PAD         = 4'h0;
	localparam int unsigned RW_BIT           = 0;
	localparam int unsigned MSB_BIT          = 7;
	// Bus address of the switch: value is arbitrary
	localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h71;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CORE_PERIOD_NS      = 10;
	localparam int unsigned RELEASE_HOLD_NS     = 100;
	localparam int unsigned RELEASE_HOLD_CYCLES =
		(RELEASE_HOLD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam logic [3:0]  HOLD_LOAD           = 4'(RELEASE_HOLD_CYCLES - 1);

	// ----------------------------------------------------------------
	// State encodings
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		REP_IDLE = 4'h1,
		REP_UP   = 4'h2,
		REP_DOWN = 4'h4,
		REP_HOLD = 4'h8
	} qcs_rep_state_type;

	typedef enum logic [6:0] {
		SLV_IDLE      = 7'h01,
		SLV_ADDR      = 7'h02,
		SLV_ACK_ADDR  = 7'h04,
		SLV_WRITE     = 7'h08,
		SLV_ACK_WRITE = 7'h10,
		SLV_READ      = 7'h20,
		SLV_ACK_READ  = 7'h40
	} qcs_slv_state_type;

endpackage : qcs_pkg

// [design/qcs_line_repeater.sv]
`timescale 1ns/10ps
`default_nettype none

module qcs_line_repeater (
	input  wire logic                          i_core_clk,
	input  wire logic                          i_reset_n,
	input  wire logic                          i_up,
	input  wire logic [qcs_pkg::CHANNELS-1:0]  i_down,
	input  wire logic [qcs_pkg::CHANNELS-1:0]  i_sel,
	output logic                               o_up_oe_n,
	output logic      [qcs_pkg::CHANNELS-1:0]  o_down_oe_n
);
	import qcs_pkg::*;

	qcs_rep_state_type     state;
	qcs_rep_state_type     next_state;
	logic [3:0]            hold_cnt;
	logic                  any_down_low;

	assign any_down_low = |(~i_down & i_sel);

	// ----------------------------------------------------------------
	// Direction arbitration: first side to pull low owns the line
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			REP_IDLE: begin
				if (!i_up) begin
					next_state = REP_UP;
				end else if (any_down_low) begin
					next_state = REP_DOWN;
				end
			end
			REP_UP: begin
				if (i_up) begin
					next_state = REP_HOLD;
				end
			end
			REP_DOWN: begin
				if (!any_down_low) begin
					next_state = REP_HOLD;
				end
			end
			REP_HOLD: begin
				// Lets released lines rise before looking again
				if (hold_cnt == 4'h0) begin
					next_state = REP_IDLE;
				end
			end
			default: begin
				next_state = REP_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= REP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hold_cnt <= 4'h0;
		end else if (state != REP_HOLD) begin
			hold_cnt <= HOLD_LOAD;
		end else if (hold_cnt != 4'h0) begin
			hold_cnt <= hold_cnt - 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Drivers, low enable means pulling the wire low
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_up_oe_n   <= 1'h1;
			o_down_oe_n <= 4'hf;
		end else begin
			o_up_oe_n   <= (next_state != REP_DOWN);
			o_down_oe_n <= (next_state == REP_UP) ? ~i_sel : 4'hf;
		end
	end

endmodule : qcs_line_repeater

`default_nettype wire

// [design/qcs_switch.sv]
// Behaviour
// - One upstream clock and data pair fans out to four independent downstream channels.
// - Traffic passes both ways between the upstream pair and every selected channel.
// - The host selects channels by writing the switch over the upstream bus, not by pins.
// - Any one channel or any combination of the four may be connected at once.
// - Four active-low interrupt inputs exist, one per downstream channel.
// - The interrupt output is the AND of the four inputs, low when any is low.
// - Holding reset low clears the bus state machine and deselects every channel.
`timescale 1ns/10ps
`default_nettype none

module qcs_switch #(
	parameter logic [6:0] DEV_ADDR = qcs_pkg::DEV_ADDR_DEFAULT
) (
	input  wire logic                          i_core_clk,
	input  wire logic                          i_link_clk,
	input  wire logic                          i_reset_n,
	input  wire logic                          i_up_scl,
	input  wire logic                          i_up_sda,
	output logic                               o_up_scl_out,
	output logic                               o_up_scl_oe_n,
	output logic                               o_up_sda_out,
	output logic                               o_up_sda_oe_n,
	input  wire logic [qcs_pkg::CHANNELS-1:0]  i_downstream_clock_data_pair_scl,
	input  wire logic [qcs_pkg::CHANNELS-1:0]  i_downstream_clock_data_pair_sda,
	output logic      [qcs_pkg::CHANNELS-1:0]  o_downstream_clock_data_pair_scl_out,
	output logic      [qcs_pkg::CHANNELS-1:0]  o_downstream_clock_data_pair_scl_oe_n,
	output logic      [qcs_pkg::CHANNELS-1:0]  o_downstream_clock_data_pair_sda_out,
	output logic      [qcs_pkg::CHANNELS-1:0]  o_downstream_clock_data_pair_sda_oe_n,
	input  wire logic [qcs_pkg::CHANNELS-1:0]  i_channel_irq_inputs_n,
	output logic                               o_irq_n,
	output logic      [qcs_pkg::CHANNELS-1:0]  o_channel_select
);
	import qcs_pkg::*;

	// ----------------------------------------------------------------
	// Link domain: pin sampling and edge detection
	// ----------------------------------------------------------------
	logic                  l_scl_m1, l_scl_s, l_scl_p;
	logic                  l_sda_m1, l_sda_s, l_sda_p;
	logic                  scl_rise, scl_fall, bus_start, bus_stop;

	always_ff @(posedge i_link_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			l_scl_m1 <= 1'h1;
			l_scl_s  <= 1'h1;
			l_scl_p  <= 1'h1;
			l_sda_m1 <= 1'h1;
			l_sda_s  <= 1'h1;
			l_sda_p  <= 1'h1;
		end else begin
			l_scl_m1 <= i_up_scl;
			l_scl_s  <= l_scl_m1;
			l_scl_p  <= l_scl_s;
			l_sda_m1 <= i_up_sda;
			l_sda_s  <= l_sda_m1;
			l_sda_p  <= l_sda_s;
		end
	end

	assign scl_rise  = l_scl_s & ~l_scl_p;
	assign scl_fall  = ~l_scl_s & l_scl_p;
	assign bus_start = l_scl_s & l_scl_p & l_sda_p & ~l_sda_s;
	assign bus_stop  = l_scl_s & l_scl_p & ~l_sda_p & l_sda_s;

	// ----------------------------------------------------------------
	// Link domain: bus target that holds the control register
	// ----------------------------------------------------------------
	qcs_slv_state_type     slv_state;
	logic [7:0]            shift;
	logic [3:0]            bit_cnt;
	logic                  rw;
	logic                  slv_drive_low;
	logic [3:0]            pend_sel;
	logic                  pend_valid;
	logic [3:0]            link_sel;
	logic                  sel_tgl;

	always_ff @(posedge i_link_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			slv_state     <= SLV_IDLE;
			shift         <= 8'h00;
			bit_cnt       <= 4'h0;
			rw            <= 1'h0;
			slv_drive_low <= 1'h0;
		end else if (bus_start) begin
			slv_state     <= SLV_ADDR;
			bit_cnt       <= 4'h0;
			slv_drive_low <= 1'h0;
		end else if (bus_stop) begin
			slv_state     <= SLV_IDLE;
			slv_drive_low <= 1'h0;
		end else begin
			unique case (slv_state)
				SLV_IDLE: begin
				end
				SLV_ADDR: begin
					if (scl_rise) begin
						shift   <= {shift[6:0], l_sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == BYTE_BITS) begin
						if (shift[7:1] == DEV_ADDR) begin
							slv_state     <= SLV_ACK_ADDR;
							rw            <= shift[RW_BIT];
							slv_drive_low <= 1'h1;
						end else begin
							slv_state <= SLV_IDLE;
						end
					end
				end
				SLV_ACK_ADDR: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (rw) begin
							slv_state     <= SLV_READ;
							shift         <= {READ_PAD, link_sel};
							slv_drive_low <= ~READ_PAD[MSB_BIT-4];
						end else begin
							slv_state     <= SLV_WRITE;
							slv_drive_low <= 1'h0;
						end
					end
				end
				SLV_WRITE: begin
					if (scl_rise) begin
						shift   <= {shift[6:0], l_sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == BYTE_BITS) begin
						slv_state     <= SLV_ACK_WRITE;
						slv_drive_low <= 1'h1;
					end
				end
				SLV_ACK_WRITE: begin
					if (scl_fall) begin
						slv_state     <= SLV_WRITE;
						bit_cnt       <= 4'h0;
						slv_drive_low <= 1'h0;
					end
				end
				SLV_READ: begin
					// Byte is never wider than the pad plus selection
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt == BYTE_BITS) begin
							slv_state     <= SLV_ACK_READ;
							slv_drive_low <= 1'h0;
						end else begin
							shift         <= {shift[6:0], 1'h0};
							slv_drive_low <= ~shift[MSB_BIT-1];
						end
					end
				end
				SLV_ACK_READ: begin
					if (scl_rise && l_sda_s) begin
						slv_state <= SLV_IDLE;
					end else if (scl_fall) begin
						slv_state     <= SLV_READ;
						bit_cnt       <= 4'h0;
						shift         <= {READ_PAD, link_sel};
						slv_drive_low <= ~READ_PAD[MSB_BIT-4];
					end
				end
				default: begin
					slv_state <= SLV_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Link domain: pending selection, committed at stop or start
	// ----------------------------------------------------------------
	always_ff @(posedge i_link_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pend_sel   <= SEL_RESET;
			pend_valid <= 1'h0;
			link_sel   <= SEL_RESET;
			sel_tgl    <= 1'h0;
		end else if (bus_stop || bus_start) begin
			pend_valid <= 1'h0;
			if (pend_valid) begin
				link_sel <= pend_sel;
				sel_tgl  <= ~sel_tgl;
			end
		end else if (slv_state == SLV_WRITE && scl_fall && bit_cnt == BYTE_BITS) begin
			pend_sel   <= shift[CHANNELS-1:0];
			pend_valid <= 1'h1;
		end
	end

	// ----------------------------------------------------------------
	// Core domain: selection crossing by toggle
	// ----------------------------------------------------------------
	logic                  c_tgl_m1, c_tgl_s, c_tgl_p;
	logic [3:0]            core_sel;

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			c_tgl_m1 <= 1'h0;
			c_tgl_s  <= 1'h0;
			c_tgl_p  <= 1'h0;
			core_sel <= SEL_RESET;
		end else begin
			c_tgl_m1 <= sel_tgl;
			c_tgl_s  <= c_tgl_m1;
			c_tgl_p  <= c_tgl_s;
			// Link copy is stable for several edges after its toggle
			if (c_tgl_s != c_tgl_p) begin
				core_sel <= link_sel;
			end
		end
	end

	assign o_channel_select = core_sel;

	// ----------------------------------------------------------------
	// Core domain: pin synchronisers
	// ----------------------------------------------------------------
	logic [LINES-1:0]      c_up_m1, c_up_s;
	logic [CHANNELS-1:0]   c_down_m1 [LINES];
	logic [CHANNELS-1:0]   c_down_s  [LINES];
	logic [CHANNELS-1:0]   c_irq_m1, c_irq_s;
	logic [LINES-1:0]      up_oe_n;
	logic [CHANNELS-1:0]   down_oe_n [LINES];

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			c_up_m1      <= 2'h3;
			c_up_s       <= 2'h3;
			c_down_m1[0] <= 4'hf;
			c_down_m1[1] <= 4'hf;
			c_down_s[0]  <= 4'hf;
			c_down_s[1]  <= 4'hf;
			c_irq_m1     <= 4'hf;
			c_irq_s      <= 4'hf;
			o_irq_n      <= 1'h1;
		end else begin
			c_up_m1      <= {i_up_sda, i_up_scl};
			c_up_s       <= c_up_m1;
			c_down_m1[LINE_SCL] <= i_downstream_clock_data_pair_scl;
			c_down_m1[LINE_SDA] <= i_downstream_clock_data_pair_sda;
			c_down_s[0]  <= c_down_m1[0];
			c_down_s[1]  <= c_down_m1[1];
			c_irq_m1     <= i_channel_irq_inputs_n;
			c_irq_s      <= c_irq_m1;
			o_irq_n      <= &c_irq_s;
		end
	end

	// ----------------------------------------------------------------
	// Repeaters, one for clock and one for data
	// ----------------------------------------------------------------
	for (genvar g = 0; g < LINES; g++) begin : g_line
		qcs_line_repeater u_rep (
			.i_core_clk  (i_core_clk),
			.i_reset_n   (i_reset_n),
			.i_up        (c_up_s[g]),
			.i_down      (c_down_s[g]),
			.i_sel       (core_sel),
			.o_up_oe_n   (up_oe_n[g]),
			.o_down_oe_n (down_oe_n[g])
		);
	end

	assign o_up_scl_out  = 1'h0;
	assign o_up_sda_out  = 1'h0;
	assign o_up_scl_oe_n = up_oe_n[LINE_SCL];
	assign o_up_sda_oe_n = up_oe_n[LINE_SDA] & ~slv_drive_low;
	assign o_downstream_clock_data_pair_scl_out  = 4'h0;
	assign o_downstream_clock_data_pair_sda_out  = 4'h0;
	assign o_downstream_clock_data_pair_scl_oe_n = down_oe_n[LINE_SCL];
	assign o_downstream_clock_data_pair_sda_oe_n = down_oe_n[LINE_SDA];

endmodule : qcs_switch

`default_nettype wire

// [verification/qcs_switch_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module qcs_switch_sva (
	input wire logic                         i_core_clk,
	input wire logic                         i_reset_n,
	input wire logic                         i_up_scl,
	input wire logic                         i_up_sda,
	input wire logic [qcs_pkg::CHANNELS-1:0] o_downstream_clock_data_pair_scl_oe_n,
	input wire logic [qcs_pkg::CHANNELS-1:0] o_downstream_clock_data_pair_sda_oe_n,
	input wire logic [qcs_pkg::CHANNELS-1:0] i_channel_irq_inputs_n,
	input wire logic                         o_irq_n,
	input wire logic [qcs_pkg::CHANNELS-1:0] o_channel_select
);
	import qcs_pkg::*;
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	a_sel_after_reset: assert property ($rose(i_reset_n) |-> o_channel_select == SEL_RESET
		&& &o_downstream_clock_data_pair_scl_oe_n) else $error("selection not cleared");
	a_irq_any_low: assert property ((!(&i_channel_irq_inputs_n))[*4] |-> !o_irq_n)
		else $error("interrupt output not low");
	a_irq_all_high: assert property ((&i_channel_irq_inputs_n)[*4] |-> o_irq_n)
		else $error("interrupt output not high");
	a_unsel_scl_quiet: assert property ((~o_channel_select & ~$past(o_channel_select)
		& ~o_downstream_clock_data_pair_scl_oe_n) == 4'h0) else $error("unselected clock driven");
	a_unsel_sda_quiet: assert property ((~o_channel_select & ~$past(o_channel_select)
		& ~o_downstream_clock_data_pair_sda_oe_n) == 4'h0) else $error("unselected data driven");
	a_up_high_scl: assert property (i_up_scl[*8] |-> &o_downstream_clock_data_pair_scl_oe_n)
		else $error("downstream clock held");
	a_up_high_sda: assert property (i_up_sda[*8] |-> &o_downstream_clock_data_pair_sda_oe_n)
		else $error("downstream data held");
	a_sel_moves_idle: assert property ($changed(o_channel_select) |-> i_up_scl && i_up_sda)
		else $error("selection changed inside transfer");
endmodule : qcs_switch_sva
`default_nettype wire

// [verification/qcs_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module qcs_host_model (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic     o_scl_low,
	output logic     o_sda_low
);
	// ----------------------------------------
	// Bus controller, open drain, 240 ns steps
	// ----------------------------------------
	initial begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
	end
	task automatic w();
		repeat (24) @(posedge i_clk);
	endtask : w
	task automatic bit_x(input logic b, output logic r);
		o_sda_low <= !b;
		w();
		o_scl_low <= 1'b0;
		w();
		r = i_sda;
		o_scl_low <= 1'b1;
		w();
	endtask : bit_x
	task automatic start();
		o_sda_low <= 1'b1;
		w();
		o_scl_low <= 1'b1;
		w();
	endtask : start
	task automatic stop();
		o_sda_low <= 1'b1;
		w();
		o_scl_low <= 1'b0;
		w();
		o_sda_low <= 1'b0;
		w();
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
		output logic a);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], b);
			r = {r[6:0], b};
		end
		bit_x(last, a);
	endtask : xfer
endmodule : qcs_host_model
`default_nettype wire

// [verification/qcs_switch_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module qcs_switch_tb;
	import qcs_pkg::*;
	localparam logic [6:0] ADDR = DEV_ADDR_DEFAULT;
	logic            core_clk = 1'b0;
	logic            link_clk = 1'b0;
	logic            reset_n = 1'b0;
	logic [3:0]      irq_n = 4'hF;
	logic [3:0]      dev_scl_low = 4'h0;
	logic            h_scl, h_sda, up_scl_oe_n, up_sda_oe_n, irq_out_n;
	logic [3:0]      dn_scl_oe_n, dn_sda_oe_n, sel;
	logic [9:0]      drv_out;
	int              err_count, comparisons;
	wire logic       up_scl = !h_scl & up_scl_oe_n;
	wire logic       up_sda = !h_sda & up_sda_oe_n;
	wire logic [3:0] dn_scl = dn_scl_oe_n & ~dev_scl_low;
	always #5 core_clk = ~core_clk;
	always #16 link_clk = ~link_clk;
	qcs_host_model i_qcs_host_model (.i_clk(core_clk), .i_sda(up_sda), .o_scl_low(h_scl),
		.o_sda_low(h_sda));
	qcs_switch #(.DEV_ADDR(ADDR)) i_qcs_switch (
		.i_core_clk(core_clk), .i_link_clk(link_clk), .i_reset_n(reset_n),
		.i_up_scl(up_scl), .i_up_sda(up_sda), .o_up_scl_out(drv_out[0]),
		.o_up_sda_out(drv_out[1]),
		.o_up_scl_oe_n(up_scl_oe_n), .o_up_sda_oe_n(up_sda_oe_n),
		.i_downstream_clock_data_pair_scl(dn_scl),
		.i_downstream_clock_data_pair_sda(dn_sda_oe_n),
		.o_downstream_clock_data_pair_scl_out(drv_out[5:2]),
		.o_downstream_clock_data_pair_sda_out(drv_out[9:6]),
		.o_downstream_clock_data_pair_scl_oe_n(dn_scl_oe_n),
		.o_downstream_clock_data_pair_sda_oe_n(dn_sda_oe_n),
		.i_channel_irq_inputs_n(irq_n), .o_irq_n(irq_out_n), .o_channel_select(sel));
	// ----------------------------------------
	// Shared tasks and scenarios
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic summarize();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	task automatic wait_sel(input logic [3:0] exp);
		int n;
		n = 0;
		while (sel !== exp && n < 60) begin
			cyc(1);
			n++;
		end
		chk("selection", {4'h0, exp}, {4'h0, sel});
		if (sel !== exp) summarize();
	endtask : wait_sel
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic k_exp);
		logic [7:0] r;
		logic k;
		logic [3:0] old;
		old = sel;
		i_qcs_host_model.start();
		i_qcs_host_model.xfer({a, 1'b0}, 1'b1, r, k);
		chk("address ack", {7'h00, k_exp}, {7'h00, k});
		i_qcs_host_model.xfer(d, 1'b1, r, k);
		chk("data ack", {7'h00, k_exp}, {7'h00, k});
		chk("held selection", {4'h0, old}, {4'h0, sel});
		i_qcs_host_model.stop();
	endtask : wr
	task automatic t_write();
		logic [7:0] v [6];
		v = '{8'h01, 8'h02, 8'h04, 8'h08, 8'hF5, 8'h0A};
		for (int i = 0; i < 6; i++) begin
			wr(ADDR, v[i], 1'b0);
			wait_sel(v[i][3:0]);
		end
	endtask : t_write
	task automatic t_read();
		logic [7:0] r;
		logic k;
		i_qcs_host_model.start();
		i_qcs_host_model.xfer({ADDR, 1'b1}, 1'b1, r, k);
		chk("read ack", 8'h00, {7'h00, k});
		i_qcs_host_model.xfer(8'hFF, 1'b1, r, k);
		chk("read byte", 8'h0A, r);
		i_qcs_host_model.stop();
	endtask : t_read
	task automatic t_pass();
		i_qcs_host_model.o_scl_low <= 1'b1;
		cyc(8);
		chk("downstream clock", 8'h05, {4'h0, dn_scl_oe_n});
		i_qcs_host_model.o_scl_low <= 1'b0;
		cyc(20);
		for (int i = 0; i < 2; i++) begin
			dev_scl_low <= 4'h2 >> i;
			cyc(8);
			chk("upstream clock", {7'h00, 1'(i)}, {7'h00, up_scl_oe_n});
			dev_scl_low <= 4'h0;
			cyc(20);
		end
	endtask : t_pass
	task automatic t_irq();
		for (int i = 0; i < 4; i++) begin
			irq_n <= ~(4'h1 << i);
			cyc(5);
			chk("interrupt low", 8'h00, {7'h00, irq_out_n});
			irq_n <= 4'hF;
			cyc(5);
			chk("interrupt high", 8'h01, {7'h00, irq_out_n});
		end
	endtask : t_irq
	task automatic t_rst();
		dev_scl_low <= 4'h2;
		cyc(8);
		reset_n <= 1'b0;
		cyc(10);
		chk("reset state", 8'h03, {4'h0, sel, up_scl_oe_n, up_sda_oe_n});
		dev_scl_low <= 4'h0;
		reset_n <= 1'b1;
		cyc(10);
		wr(ADDR, 8'h03, 1'b0);
		wait_sel(4'h3);
	endtask : t_rst
	initial begin
		err_count = 0;
		comparisons = 0;
		cyc(6);
		reset_n <= 1'b1;
		cyc(3);
		chk("idle lines", 8'hFF, {dn_scl_oe_n, dn_sda_oe_n});
		chk("idle state", 8'h07, {sel, 1'b0, up_scl_oe_n, up_sda_oe_n, irq_out_n});
		chk("driven level", 8'h00, drv_out[7:0]);
		chk("driven level", 8'h00, {6'h00, drv_out[9:8]});
		t_write();
		t_read();
		wr(ADDR ^ 7'h01, 8'h0F, 1'b1);
		cyc(40);
		chk("foreign address", 8'h0A, {4'h0, sel});
		t_pass();
		t_irq();
		t_rst();
		summarize();
	end
endmodule : qcs_switch_tb
bind qcs_switch qcs_switch_sva i_qcs_switch_sva (.*);
`default_nettype wire
